// file: shared/irtp_defs.svh
// constants for the two-wire register target port
// assumes inclusion by the package and the design files
`ifndef IRTP_DEFS_SVH
`define IRTP_DEFS_SVH
`define IRTP_ADDR_BASE2 3'h5
`define IRTP_ADDR_BASE1 5'h14
`define IRTP_ADDR_FIXED 7'h54
`define IRTP_HS_CODE 5'h01
`define IRTP_PSEL_FLOAT 2'h0
`define IRTP_PSEL_GND 2'h1
`define IRTP_PSEL_SUPPLY 2'h2
`define IRTP_PKG_TWO 2'h0
`define IRTP_PKG_ONE 2'h1
`define IRTP_PKG_NONE 2'h2
`define IRTP_BIT_LAST 4'h7
`define IRTP_BIT_ACK 4'h8
`define IRTP_BIT_START 4'hf
`define IRTP_PTR_RST 8'h00
`endif

// file: shared/irtp_pkg.sv
// types for the two-wire register target port
// assumes irtp_defs.svh is on the include path
`include "irtp_defs.svh"
package irtp_pkg;
    // pin level of one address-select input as seen by the pad
    typedef struct packed {
        logic to_gnd;
        logic to_supply;
    } irtp_psel_t;
    // register-side request towards the device's register file
    typedef struct packed {
        logic wr_upper;
        logic wr_lower;
        logic rd_word;
        logic [7:0] ptr;
        logic [7:0] data;
    } irtp_req_t;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_RECV = 6'b000010,
        ST_ACK = 6'b000100,
        ST_SEND = 6'b001000,
        ST_MACK = 6'b010000,
        ST_IGN = 6'b100000
    } irtp_state_t;
endpackage

// file: hw/irtp_sync.sv
// two flip-flop synchroniser for a group of levels
// assumes the inputs are asynchronous to clk
`timescale 1ns/100ps
module irtp_sync #(
    parameter int W = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    // ==========================================
    // sync stages
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '1;
            q_o <= '1;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// file: hw/irtp_target.sv
// two-wire register target port: bus decode, addressing, pointer, byte moves
// assumes scl/sda pins sampled on link_clk_i, register file on clk_i
// What this block does
// - ack matching address by pulling data low; leave released on mismatch.
// - during master write, ack every received byte including pointer.
// - repeated start begins new address phase, speed mode unchanged.
// - stop is data rising with clock high; bus then idle.
// - seven-bit address plus read/write bit, device answers ninth slot.
// - first written byte after address loads the pointer, acked.
// - upper then lower byte written, each acked.
// - after a word write accept more pairs, repeated start or stop.
// - read sends upper byte of pointed register right after address ack.
// - master ack after upper sends lower, then pairs repeat unlimited.
// - high-speed master code 00001xxx is not acknowledged.
// - after master code, hs_mode_o flags high-speed; repeated start decodes with the same logic as before.
// - high-speed persists across repeated starts, ends only at stop.
// - select pins ground, float or supply; mid-supply on first pin floats.
// - two-pin address is 101, second pin code, first pin code.
// - one-pin address is 10100 followed by pin code.
// - pinless variant answers only the fixed address.
// - pointer held between transactions, changed only by write first byte.
`timescale 1ns/100ps
module irtp_target
    import irtp_pkg::*;
#(
    parameter logic [1:0] PKG_VARIANT = `IRTP_PKG_TWO
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire irtp_pkg::irtp_psel_t address_select_first_pin_i,
    input wire irtp_pkg::irtp_psel_t address_select_second_pin_i,
    output irtp_pkg::irtp_req_t req_o,
    output logic req_valid_o,
    input wire logic [15:0] rd_word_i,
    output logic hs_mode_o
);
    import irtp_pkg::*;

    // ==========================================
    // pin synchronisers on the link clock
    logic [1:0] pin_s;
    irtp_sync #(.W(2)) u_pin_sync (
        .clk_i(link_clk_i),
        .rst_i(sys_rst_i),
        .d_i({scl_i, sda_i}),
        .q_o(pin_s)
    );
    logic scl_q, sda_q;
    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= pin_s[1];
            sda_q <= pin_s[0];
        end
    end
    wire scl_s = pin_s[1];
    wire sda_s = pin_s[0];
    wire start_det = scl_s && scl_q && sda_q && !sda_s;
    wire stop_det = scl_s && scl_q && !sda_q && sda_s;
    wire scl_rise = scl_s && !scl_q;
    wire scl_fall = !scl_s && scl_q;

    // ==========================================
    // own address from select pins, two flops as for any pin
    logic [3:0] sel_s;
    irtp_sync #(.W(4)) u_sel_sync (
        .clk_i(link_clk_i),
        .rst_i(sys_rst_i),
        .d_i({address_select_second_pin_i, address_select_first_pin_i}),
        .q_o(sel_s)
    );
    function automatic logic [1:0] psel_code(input irtp_psel_t p);
        // mid-supply reads as neither rail, same as floating
        psel_code = p.to_gnd ? `IRTP_PSEL_GND :
                    p.to_supply ? `IRTP_PSEL_SUPPLY : `IRTP_PSEL_FLOAT;
    endfunction
    wire [1:0] code_a = psel_code(irtp_psel_t'(sel_s[1:0]));
    wire [1:0] code_b = psel_code(irtp_psel_t'(sel_s[3:2]));
    wire [6:0] addr_two = {`IRTP_ADDR_BASE2, code_b, code_a};
    wire [6:0] addr_one = {`IRTP_ADDR_BASE1, code_a};
    wire [6:0] own_addr = (PKG_VARIANT == `IRTP_PKG_TWO) ? addr_two :
                          (PKG_VARIANT == `IRTP_PKG_ONE) ? addr_one :
                          `IRTP_ADDR_FIXED;

    // ==========================================
    // link-side byte engine
    irtp_state_t st_q, st_d;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic addr_ph_q, rw_q, first_q, upper_q, drive_q, hs_q;
    logic [7:0] ptr_q;
    logic [7:0] tx_q;
    logic ev_tgl_q;
    logic [1:0] ev_kind_q;
    logic [7:0] ev_data_q;
    logic [15:0] rd_q;

    wire [7:0] rx_byte = {sh_q[6:0], sda_s};
    wire addr_hit = rx_byte[7:1] == own_addr;
    wire hs_code = rx_byte[7:3] == `IRTP_HS_CODE;
    wire byte_done = scl_rise && (bit_q == `IRTP_BIT_LAST);

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: st_d = ST_IDLE;
            ST_RECV: if (byte_done) begin
                if (addr_ph_q && !addr_hit)
                    st_d = ST_IGN;
                else
                    st_d = ST_ACK;
            end
            ST_ACK: if (scl_fall && bit_q == `IRTP_BIT_ACK)
                st_d = (rw_q) ? ST_SEND : ST_RECV;
            ST_SEND: if (byte_done) st_d = ST_MACK;
            ST_MACK: if (scl_rise)
                st_d = sda_s ? ST_IGN : ST_SEND;
            ST_IGN: st_d = ST_IGN;
            default: st_d = ST_IDLE;
        endcase
        if (start_det) st_d = ST_RECV;
        if (stop_det) st_d = ST_IDLE;
    end

    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            addr_ph_q <= 1'b0;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            upper_q <= 1'b1;
            hs_q <= 1'b0;
            ptr_q <= `IRTP_PTR_RST;
            tx_q <= 8'h00;
            ev_tgl_q <= 1'b0;
            ev_kind_q <= 2'h0;
            ev_data_q <= 8'h00;
        end else begin
            st_q <= st_d;
            if (start_det || stop_det) begin
                bit_q <= `IRTP_BIT_START;
                addr_ph_q <= start_det;
                upper_q <= 1'b1;
                if (stop_det) hs_q <= 1'b0;
            end else begin
                if (scl_rise && (st_q == ST_RECV || st_q == ST_SEND))
                    sh_q <= rx_byte;
                if (scl_fall && st_q != ST_IDLE && st_q != ST_IGN)
                    bit_q <= (bit_q == `IRTP_BIT_ACK) ? 4'h0 : bit_q + 4'h1;
                if (st_q == ST_RECV && byte_done) begin
                    if (addr_ph_q) begin
                        addr_ph_q <= 1'b0;
                        rw_q <= rx_byte[0];
                        first_q <= ~rx_byte[0];
                        if (hs_code) hs_q <= 1'b1;
                        if (addr_hit && rx_byte[0]) begin
                            ev_tgl_q <= ~ev_tgl_q;
                            ev_kind_q <= 2'h3;
                        end
                    end else if (first_q) begin
                        ptr_q <= rx_byte;
                        first_q <= 1'b0;
                    end else begin
                        ev_tgl_q <= ~ev_tgl_q;
                        ev_kind_q <= upper_q ? 2'h1 : 2'h2;
                        ev_data_q <= rx_byte;
                        upper_q <= ~upper_q;
                    end
                end
                if (st_q == ST_ACK && scl_fall && rw_q)
                    tx_q <= upper_q ? rd_q[15:8] : rd_q[7:0];
                if (st_q == ST_MACK && scl_rise && !sda_s)
                    upper_q <= ~upper_q;
                if (st_q == ST_SEND && scl_fall && bit_q == `IRTP_BIT_ACK)
                    tx_q <= upper_q ? rd_q[15:8] : rd_q[7:0];
                else if (st_q == ST_SEND && scl_fall)
                    tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // data pin drive changes only while clock low
    wire ack_slot = (st_q == ST_ACK);
    wire send_low = (st_q == ST_SEND) && (bit_q != `IRTP_BIT_ACK) && !tx_q[7];
    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            drive_q <= 1'b0;
        else if (start_det || stop_det)
            drive_q <= 1'b0;
        else if (!scl_s)
            drive_q <= ack_slot || send_low;
    end
    assign sda_o = 1'b0;
    assign sda_oe_o = drive_q;

    // ==========================================
    // crossing: toggle events to clk_i, read word back to link
    logic [2:0] ev_s_q;
    logic [15:0] rd_word_q;
    logic [15:0] rd_s1_q;
    logic hs_s_q;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ev_s_q <= 3'h0;
            hs_s_q <= 1'b0;
            req_o <= '0;
            req_valid_o <= 1'b0;
            rd_word_q <= 16'h0000;
            hs_mode_o <= 1'b0;
        end else begin
            ev_s_q <= {ev_s_q[1:0], ev_tgl_q};
            req_valid_o <= ev_s_q[2] ^ ev_s_q[1];
            if (ev_s_q[2] ^ ev_s_q[1]) begin
                req_o.wr_upper <= ev_kind_q == 2'h1;
                req_o.wr_lower <= ev_kind_q == 2'h2;
                req_o.rd_word <= ev_kind_q == 2'h3;
                req_o.ptr <= ptr_q;
                req_o.data <= ev_data_q;
            end
            rd_word_q <= rd_word_i;
            hs_s_q <= hs_q;
            hs_mode_o <= hs_s_q;
        end
    end
    // word is quasi-static; sampled twice on link side
    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_s1_q <= 16'h0000;
            rd_q <= 16'h0000;
        end else begin
            rd_s1_q <= rd_word_q;
            rd_q <= rd_s1_q;
        end
    end

    // ==========================================
    // checks
    property p_nack_mismatch;
        @(posedge link_clk_i) disable iff (sys_rst_i)
        (st_q == ST_RECV && byte_done && addr_ph_q && !addr_hit && !start_det && !stop_det)
            |=> st_q == ST_IGN;
    endproperty
    a_nack_mismatch: assert property (p_nack_mismatch) else $error("no ignore on miss");
    property p_ign_quiet;
        @(posedge link_clk_i) disable iff (sys_rst_i)
        (st_q == ST_IGN) ##1 (st_q == ST_IGN) |-> !sda_oe_o;
    endproperty
    a_ign_quiet: assert property (p_ign_quiet) else $error("drive while ignoring");
    property p_stop_idle;
        @(posedge link_clk_i) disable iff (sys_rst_i)
        stop_det |=> st_q == ST_IDLE && !sda_oe_o && !hs_q;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not idle");
    property p_start_addr;
        @(posedge link_clk_i) disable iff (sys_rst_i)
        start_det && !stop_det |=> st_q == ST_RECV && addr_ph_q && bit_q == `IRTP_BIT_START;
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("no address phase");
    property p_hs_keep;
        @(posedge link_clk_i) disable iff (sys_rst_i)
        hs_q && start_det |=> hs_q;
    endproperty
    a_hs_keep: assert property (p_hs_keep) else $error("hs lost on restart");
    property p_ptr_hold;
        @(posedge link_clk_i) disable iff (sys_rst_i)
        !(st_q == ST_RECV && first_q && byte_done) |=> ptr_q == $past(ptr_q);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) else $error("pointer changed");
    property p_ptr_load;
        @(posedge link_clk_i) disable iff (sys_rst_i)
        st_q == ST_RECV && first_q && !addr_ph_q && byte_done && !start_det && !stop_det
            |=> ptr_q == $past(rx_byte);
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");
    property p_mnack_release;
        @(posedge link_clk_i) disable iff (sys_rst_i)
        st_q == ST_MACK && scl_rise && sda_s && !start_det && !stop_det |=> st_q == ST_IGN;
    endproperty
    a_mnack_release: assert property (p_mnack_release) else $error("send after nack");
    property p_addr_two;
        @(posedge link_clk_i) disable iff (sys_rst_i)
        PKG_VARIANT == `IRTP_PKG_TWO |-> own_addr[6:4] == `IRTP_ADDR_BASE2;
    endproperty
    a_addr_two: assert property (p_addr_two) else $error("bad address prefix");
    property p_ack_drive;
        @(posedge link_clk_i) disable iff (sys_rst_i)
        st_q == ST_ACK && !scl_s && !start_det && !stop_det |=> sda_oe_o;
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");
    c_write: cover property (@(posedge link_clk_i) st_q == ST_RECV && first_q && byte_done);
    c_read: cover property (@(posedge link_clk_i) st_q == ST_MACK && scl_rise && !sda_s);
    c_hs: cover property (@(posedge link_clk_i) hs_q && start_det);
endmodule

// file: verif/irtp_master_model.sv
// behavioural two-wire bus master for the register target port
// assumes a pull-up on the data line: a released line reads high
`timescale 1ns/100ps
module irtp_master_model #(
    parameter int QUARTER_NS = 384
) (
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // ==========================================
    // idle bus: both lines released
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // ==========================================
    // start or repeated start, data falls with clock high
    task automatic bus_start();
        sda_low_o = 1'b0;
        #(QUARTER_NS);
        scl_o = 1'b1;
        #(QUARTER_NS);
        sda_low_o = 1'b1;
        #(QUARTER_NS);
        scl_o = 1'b0;
        #(QUARTER_NS);
    endtask
    // stop, data rises with clock high
    task automatic bus_stop();
        sda_low_o = 1'b1;
        #(QUARTER_NS);
        scl_o = 1'b1;
        #(QUARTER_NS);
        sda_low_o = 1'b0;
        #(QUARTER_NS);
    endtask
    // one slot: data set while clock low, sampled mid high
    task automatic bus_bit(input logic tx, output logic rx);
        sda_low_o = ~tx;
        #(QUARTER_NS);
        scl_o = 1'b1;
        #(QUARTER_NS);
        rx = sda_i;
        #(QUARTER_NS);
        scl_o = 1'b0;
        #(QUARTER_NS);
    endtask
    // msb first, ninth slot released for the target
    task automatic send_byte(input logic [7:0] b, output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bus_bit(b[i], r);
        end
        bus_bit(1'b1, r);
        acked = ~r;
    endtask
    // ack asks for more, nack on the last byte
    task automatic recv_byte(input logic more, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bus_bit(1'b1, r);
            b[i] = r;
        end
        bus_bit(~more, r);
    endtask
endmodule

// file: verif/tb_top.sv
// self-checking bench for the two-wire register target port
// assumes the target in its two-pin variant and the master model beside it
`timescale 1ns/100ps
module tb_top;
    import irtp_pkg::*;
    localparam logic [7:0] DEV_W = 8'ha0;
    localparam logic [7:0] DEV_R = 8'ha1;
    logic clk_i, link_clk_i, sys_rst_i, scl, m_low;
    logic sda_o, sda_oe_o, req_valid_o, hs_mode_o;
    wire sda_bus;
    irtp_psel_t sel_a, sel_b;
    irtp_req_t req_o;
    logic [15:0] rd_word_i;
    int num_errors = 0;
    int samples_checked = 0;
    irtp_req_t events[$];
    // ==========================================
    // clocks, wired-and data line with pull-up
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        link_clk_i = 1'b0;
        forever #32 link_clk_i = ~link_clk_i;
    end
    assign sda_bus = ~(m_low | (sda_oe_o & ~sda_o));
    irtp_target dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i),
        .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .address_select_first_pin_i(sel_a), .address_select_second_pin_i(sel_b),
        .req_o(req_o), .req_valid_o(req_valid_o), .rd_word_i(rd_word_i),
        .hs_mode_o(hs_mode_o));
    irtp_master_model mst_u (.sda_i(sda_bus), .scl_o(scl), .sda_low_o(m_low));
    always @(negedge clk_i) begin
        if (req_valid_o === 1'b1) begin
            events.push_back(req_o);
        end
    end
    // ==========================================
    // shared helpers
    function automatic logic [15:0] word_of(input logic [7:0] p);
        return {p ^ 8'h3c, ~p};
    endfunction
    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic exp_ev(input logic [2:0] kind, input logic [7:0] p, input logic [7:0] d);
        irtp_req_t e;
        e = '0;
        if (events.size() > 0) begin
            e = events.pop_front();
        end
        check(({e.wr_upper, e.wr_lower, e.rd_word, e.ptr} === {kind, p})
              && (kind == 3'b001 || e.data === d), "register event wrong");
    endtask
    task automatic wait_hs(input logic v);
        int n;
        n = 0;
        while (hs_mode_o !== v && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        check(hs_mode_o === v, "speed mode flag wrong");
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic s_addr();
        irtp_psel_t lv[3];
        logic ack;
        logic [6:0] a;
        lv[0] = 2'b00;
        lv[1] = 2'b10;
        lv[2] = 2'b01;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk_i) #1;
            sel_b = lv[i/3];
            sel_a = lv[i%3];
            a = {3'b101, 2'(i/3), 2'(i%3)};
            mst_u.bus_start();
            mst_u.send_byte({a, 1'b0}, ack);
            check(ack, "own address not acked");
            mst_u.bus_start();
            mst_u.send_byte({a ^ 7'h08, 1'b0}, ack);
            check(!ack, "foreign address acked");
            mst_u.send_byte(8'h00, ack);
            check(!ack, "byte after foreign address acked");
            mst_u.bus_stop();
        end
        check(events.size() == 0, "event without data");
    endtask
    task automatic s_write();
        logic ack;
        logic [7:0] bytes[6] = '{DEV_W, 8'h04, 8'h12, 8'h34, 8'h56, 8'h78};
        mst_u.bus_start();
        foreach (bytes[i]) begin
            mst_u.send_byte(bytes[i], ack);
            check(ack, "written byte not acked");
        end
        mst_u.bus_stop();
        exp_ev(3'b100, 8'h04, 8'h12);
        exp_ev(3'b010, 8'h04, 8'h34);
        exp_ev(3'b100, 8'h04, 8'h56);
        exp_ev(3'b010, 8'h04, 8'h78);
    endtask
    task automatic s_read();
        logic ack;
        logic [7:0] b;
        logic [15:0] wd;
        @(posedge clk_i) #1;
        wd = word_of(8'h07);
        rd_word_i = wd;
        mst_u.bus_start();
        mst_u.send_byte(DEV_W, ack);
        mst_u.send_byte(8'h07, ack);
        check(ack, "pointer not acked");
        mst_u.bus_start();
        mst_u.send_byte(DEV_R, ack);
        check(ack, "read address not acked");
        for (int w = 0; w < 2; w++) begin
            mst_u.recv_byte(1'b1, b);
            check(b === wd[15:8], "upper byte wrong");
            mst_u.recv_byte(w == 0, b);
            check(b === wd[7:0], "lower byte wrong");
        end
        mst_u.recv_byte(1'b1, b);
        check(b === 8'hff, "data driven after master nack");
        mst_u.bus_stop();
        mst_u.bus_start();
        mst_u.send_byte(DEV_R, ack);
        mst_u.recv_byte(1'b0, b);
        check(b === wd[15:8], "preset pointer read wrong");
        mst_u.bus_stop();
        exp_ev(3'b001, 8'h07, 8'h00);
        exp_ev(3'b001, 8'h07, 8'h00);
    endtask
    task automatic s_hs();
        logic ack;
        for (int c = 0; c < 8; c++) begin
            mst_u.bus_start();
            mst_u.send_byte({5'h01, 3'(c)}, ack);
            check(!ack, "master code acked");
            wait_hs(1'b1);
            mst_u.bus_start();
            mst_u.send_byte(DEV_W, ack);
            check(ack && hs_mode_o === 1'b1, "high speed address failed");
            mst_u.bus_start();
            check(hs_mode_o === 1'b1, "speed lost at repeated start");
            mst_u.bus_stop();
            wait_hs(1'b0);
        end
    endtask
    // ==========================================
    // main sequence and watchdog
    initial begin
        sys_rst_i = 1'b1;
        sel_a = 2'b00;
        sel_b = 2'b00;
        rd_word_i = word_of(8'h00);
        repeat (5) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        repeat (10) @(posedge clk_i);
        check(hs_mode_o === 1'b0 && sda_oe_o === 1'b0 && sda_o === 1'b0, "reset state wrong");
        s_addr();
        @(posedge clk_i) #1;
        sel_a = 2'b00;
        sel_b = 2'b00;
        s_write();
        s_read();
        s_hs();
        check(events.size() == 0, "unexpected register event");
        print_verdict();
    end
    initial begin
        #1500000;
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule
